// *** include/cdt_pkg.sv ***
package cdt_pkg;

  // ==========================================================
  // Bus and register map
  localparam int CDT_DW = 32;
  localparam int CDT_AW = 12;
  localparam logic [11:0] CDT_OFS_CTRL = 12'h000;
  localparam logic [11:0] CDT_OFS_RELOAD = 12'h004;
  localparam logic [11:0] CDT_OFS_COUNT = 12'h008;
  localparam logic [11:0] CDT_OFS_ENABLE = 12'h00c;
  localparam logic [11:0] CDT_OFS_CASCADE = 12'h010;
  localparam logic [11:0] CDT_OFS_CMPA = 12'h020;
  localparam logic [11:0] CDT_OFS_IRQ_STAT = 12'h030;
  localparam logic [11:0] CDT_OFS_IRQ_EN = 12'h034;
  localparam logic [11:0] CDT_OFS_IRQ_CLR = 12'h038;
  localparam logic [11:0] CDT_OFS_PERID = 12'hffc;
  localparam logic [31:0] CDT_RESET_WORD = 32'h0000_0000;

  // ==========================================================
  // Field positions
  localparam int CDT_BIT_ENABLE = 0;
  localparam int CDT_BIT_ACTIVE = 1;
  localparam int CDT_BIT_STOP = 2;
  localparam int CDT_BIT_IDLE = 3;
  localparam int CDT_BIT_ZIRQ = 4;
  localparam int CDT_CSD_GATE = 0;
  localparam int CDT_CSD_STOP = 1;

  // ==========================================================
  // Interrupt events
  localparam int CDT_EV_W = 2;
  localparam int CDT_EV_EXPIRY = 0;
  localparam int CDT_EV_STOP = 1;

  // ==========================================================
  // Types
  typedef struct packed {
    logic zero_interrupt_enable;
    logic idle_at_zero;
    logic stop_at_zero;
  } cdt_ctrl_t;

  typedef struct packed {
    logic stop_en;
    logic count_gate;
  } cdt_csd_t;

  typedef enum logic [1:0] {
    CDT_IDLE = 2'b00,
    CDT_ARMED = 2'b01,
    CDT_RUN = 2'b10
  } cdt_state_t;

endpackage

// *** design/cdt_irq_regs.sv ***
module cdt_irq_regs #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Events
  input wire logic [W-1:0] event_set,
  // Software access
  input wire logic en_wr,
  input wire logic clr_wr,
  input wire logic [W-1:0] wdata,
  // State
  output logic [W-1:0] status,
  output logic [W-1:0] enable,
  output logic irq
);

  initial begin
    if (W < 1) begin
      $error("cdt_irq_regs: W must be at least 1");
    end
  end

  logic [W-1:0] status_nxt;

  // ==========================================================
  // Sticky status, set wins over a clear in the same cycle
  always_comb begin
    status_nxt = status & ~(clr_wr ? wdata : {W{1'b0}});
    status_nxt = status_nxt | event_set;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status <= '0;
    end else begin
      status <= status_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      enable <= '0;
    end else if (en_wr) begin
      enable <= wdata;
    end
  end

  assign irq = |(status & enable);

endmodule

// *** design/cdt_timer.sv ***
// Overview of operation
// - Enabled channel holds a 32-bit count decrementing from reload value.
// - Count stepping from one to zero is the single expiry event.
// - On expiry channel halts or restarts, per configuration.
// - Counting needs both the timer clock running (gate open or channel active) and enable set.
// - Enable reads one when enabled, resets to zero, clearing stops counting.
// - Closing the clock gate waits until the channel is no longer active.
// - Enabled counting still obeys the cascade count condition.
// - Active sets on first clock after enabling where the count changes.
// - Started means the count changed at least once since enabling.
// - Software clearing enable clears active.
// - Reaching zero with stop-at-zero or idle-at-zero clears active.
// - Stop-trigger cascade condition clears enable and active.
// - Stop-at-zero clears enable and active when count reaches zero.
// - Idle-at-zero acts only in continuous mode, clearing only active.
// - Zero interrupt enable gives a one-cycle pulse at each expiry.
module cdt_timer
  import cdt_pkg::*;
#(
  parameter int CNT_W = 32,
  parameter logic [31:0] PERIPH_ID = 32'h0000_0a5a // Arbitrary value
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cdt_pkg::CDT_AW-1:0] paddr,
  input wire logic [cdt_pkg::CDT_DW-1:0] pwdata,
  output logic [cdt_pkg::CDT_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // System setup and cascade
  input wire logic timer_clock_gate,
  input wire logic count_trigger,
  input wire logic stop_trigger,
  output logic timer_clock_run,
  // Interrupts
  output logic zero_irq,
  output logic irq
);
  import cdt_pkg::*;
  default clocking chk_cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  initial begin
    if (CNT_W < 2 || CNT_W > CDT_DW) begin
      $error("cdt_timer: CNT_W must lie in 2..32");
    end
  end

  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

  function automatic logic hit(input logic [CDT_AW-1:0] a,
                               input logic [CDT_AW-1:0] o);
    return a[CDT_AW-1:2] == o[CDT_AW-1:2];
  endfunction

  // ==========================================================
  // State
  logic enable_r, enable_nxt;
  cdt_state_t state_r, state_nxt;
  cdt_ctrl_t ctrl_r;
  cdt_csd_t csd_r;
  logic [CNT_W-1:0] reload_r, count_r, step_val;
  logic [CDT_DW-1:0] cmpa_r;
  logic zero_irq_r;
  logic [CDT_EV_W-1:0] irq_status, irq_enable, ev_set;

  // ==========================================================
  // Bus decode
  logic wr, wr_ctrl, wr_en_reg, wr_count, sw_en_wr, sw_en_val;
  logic setup, rd_err;
  logic [CDT_DW-1:0] rd_word;

  assign wr = psel & penable & pwrite;
  assign setup = psel & ~penable;
  assign wr_ctrl = wr & hit(paddr, CDT_OFS_CTRL);
  assign wr_en_reg = wr & hit(paddr, CDT_OFS_ENABLE);
  assign wr_count = wr & hit(paddr, CDT_OFS_COUNT);
  assign sw_en_wr = wr_ctrl | wr_en_reg;
  assign sw_en_val = pwdata[CDT_BIT_ENABLE];
  assign pready = 1'b1;

  // ==========================================================
  // Counting
  logic active, step, expiry, changed, stop_evt, halt_zero, idle_zero;

  assign active = (state_r == CDT_RUN);
  assign timer_clock_run = timer_clock_gate | active;
  assign step = timer_clock_run & enable_r &
                (~csd_r.count_gate | count_trigger);
  assign expiry = step & (count_r == CNT_ONE);
  assign halt_zero = expiry & ctrl_r.stop_at_zero;
  assign idle_zero = expiry & ~ctrl_r.stop_at_zero & ctrl_r.idle_at_zero;
  assign stop_evt = csd_r.stop_en & stop_trigger & enable_r;

  assign step_val = (count_r == CNT_ZERO) ? reload_r : count_r - CNT_ONE;
  assign changed = step & (step_val != count_r);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count_r <= CNT_ZERO;
    end else if (wr_count) begin
      count_r <= pwdata[CNT_W-1:0];
    end else if (step) begin
      count_r <= step_val;
    end
  end

  // halt or restart; auto disable; software enable
  always_comb begin
    enable_nxt = sw_en_wr ? sw_en_val : enable_r;
    if (stop_evt | halt_zero) begin
      enable_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      enable_r <= 1'b0;
    end else begin
      enable_r <= enable_nxt;
    end
  end

  // ==========================================================
  // Enabled and active states
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      CDT_IDLE: begin
        state_nxt = CDT_ARMED;
      end
      CDT_ARMED: begin
        if (changed & ~(halt_zero | idle_zero)) begin
          state_nxt = CDT_RUN;
        end
      end
      // zero with stop or idle option
      CDT_RUN: begin
        if (halt_zero | idle_zero) begin
          state_nxt = CDT_ARMED;
        end
      end
      default: begin
        state_nxt = CDT_IDLE;
      end
    endcase
    if (!enable_nxt) begin
      state_nxt = CDT_IDLE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= CDT_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_r <= '0;
    end else if (wr_ctrl) begin
      ctrl_r.stop_at_zero <= pwdata[CDT_BIT_STOP];
      ctrl_r.idle_at_zero <= pwdata[CDT_BIT_IDLE];
      ctrl_r.zero_interrupt_enable <= pwdata[CDT_BIT_ZIRQ];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      csd_r <= '0;
    end else if (wr & hit(paddr, CDT_OFS_CASCADE)) begin
      csd_r <= {pwdata[CDT_CSD_STOP], pwdata[CDT_CSD_GATE]};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reload_r <= CNT_ZERO;
    end else if (wr & hit(paddr, CDT_OFS_RELOAD)) begin
      reload_r <= pwdata[CNT_W-1:0];
    end
  end

  // Stored only; compare output lives elsewhere
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmpa_r <= CDT_RESET_WORD;
    end else if (wr & hit(paddr, CDT_OFS_CMPA)) begin
      cmpa_r <= pwdata;
    end
  end

  // ==========================================================
  // Interrupts
  // one-cycle zero pulse
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      zero_irq_r <= 1'b0;
    end else begin
      zero_irq_r <= expiry & ctrl_r.zero_interrupt_enable;
    end
  end
  assign zero_irq = zero_irq_r;

  always_comb begin
    ev_set = '0;
    ev_set[CDT_EV_EXPIRY] = expiry;
    ev_set[CDT_EV_STOP] = stop_evt;
  end

  cdt_irq_regs #(
    .W(CDT_EV_W)
  ) u_irq (
    .sys_clk(sys_clk),
    .rst(rst),
    .event_set(ev_set),
    .en_wr(wr & hit(paddr, CDT_OFS_IRQ_EN)),
    .clr_wr(wr & hit(paddr, CDT_OFS_IRQ_CLR)),
    .wdata(pwdata[CDT_EV_W-1:0]),
    .status(irq_status),
    .enable(irq_enable),
    .irq(irq)
  );

  // ==========================================================
  // Read path, captured in the setup cycle for zero-wait access
  always_comb begin
    rd_word = CDT_RESET_WORD;
    rd_err = 1'b0;
    if (hit(paddr, CDT_OFS_CTRL)) begin
      rd_word[CDT_BIT_ENABLE] = enable_r;
      rd_word[CDT_BIT_ACTIVE] = active;
      rd_word[CDT_BIT_STOP] = ctrl_r.stop_at_zero;
      rd_word[CDT_BIT_IDLE] = ctrl_r.idle_at_zero;
      rd_word[CDT_BIT_ZIRQ] = ctrl_r.zero_interrupt_enable;
    end else if (hit(paddr, CDT_OFS_ENABLE)) begin
      rd_word[CDT_BIT_ENABLE] = enable_r;
    end else if (hit(paddr, CDT_OFS_RELOAD)) begin
      rd_word = 32'(reload_r);
    end else if (hit(paddr, CDT_OFS_COUNT)) begin
      rd_word = 32'(count_r);
    end else if (hit(paddr, CDT_OFS_CASCADE)) begin
      rd_word[CDT_CSD_GATE] = csd_r.count_gate;
      rd_word[CDT_CSD_STOP] = csd_r.stop_en;
    end else if (hit(paddr, CDT_OFS_CMPA)) begin
      rd_word = cmpa_r;
    end else if (hit(paddr, CDT_OFS_IRQ_STAT)) begin
      rd_word = 32'(irq_status);
    end else if (hit(paddr, CDT_OFS_IRQ_EN)) begin
      rd_word = 32'(irq_enable);
    end else if (hit(paddr, CDT_OFS_IRQ_CLR)) begin
      rd_word = CDT_RESET_WORD;
    end else if (hit(paddr, CDT_OFS_PERID)) begin
      rd_word = PERIPH_ID;
    end else begin
      rd_err = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prdata <= CDT_RESET_WORD;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? CDT_RESET_WORD : rd_word;
      pslverr <= rd_err;
    end
  end

  // ==========================================================
  // Checks
  chk_zero_pulse_once: assert property (
    expiry && ctrl_r.zero_interrupt_enable |=> zero_irq ##1 !zero_irq)
    else $error("zero pulse not exactly one cycle");
  chk_pulse_has_cause: assert property (
    zero_irq |-> $past(expiry))
    else $error("zero pulse without expiry");
  chk_disable_clears_active: assert property (
    sw_en_wr && !sw_en_val |=> !enable_r && !active)
    else $error("disable left channel active");
  chk_auto_stop_zero: assert property (
    halt_zero |=> !enable_r && state_r == CDT_IDLE)
    else $error("stop at zero did not disable");
  chk_idle_zero_keeps: assert property (
    idle_zero && !sw_en_wr && !stop_evt |=> enable_r && !active)
    else $error("idle at zero misbehaved");
  chk_stop_cascade: assert property (
    stop_evt |=> !enable_r && !active)
    else $error("stop trigger did not disable");
  chk_no_count_off: assert property (
    !enable_r && !wr_count |=> $stable(count_r))
    else $error("count moved while disabled");
  chk_cascade_wait: assert property (
    csd_r.count_gate && !count_trigger && !wr_count |=> $stable(count_r))
    else $error("count moved without cascade");
  chk_active_sets: assert property (
    state_r == CDT_ARMED && changed && !expiry && enable_nxt |=> active)
    else $error("active not set on first change");
  chk_active_cause: assert property (
    $rose(active) |-> $past(changed))
    else $error("active without count change");
  chk_gate_deferred: assert property (
    !timer_clock_gate && active && count_r > CNT_ONE && !wr_count &&
    (!csd_r.count_gate || count_trigger)
    |=> count_r == $past(count_r) - CNT_ONE)
    else $error("count stalled with gate closed while active");
  chk_decrement_step: assert property (
    step && count_r > CNT_ONE && !wr_count
    |=> count_r == $past(count_r) - CNT_ONE)
    else $error("count did not decrement");
  chk_reload_step: assert property (
    step && count_r == CNT_ZERO && !wr_count |=> count_r == $past(reload_r))
    else $error("count did not reload");

endmodule

// *** dv/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import cdt_pkg::*;

  // ==========================================================
  // Design and stimulus signals
  localparam logic [31:0] ID_VAL = 32'h0000_3c3c; // Arbitrary value
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [CDT_AW-1:0] paddr = '0;
  logic [CDT_DW-1:0] pwdata = '0;
  logic [CDT_DW-1:0] prdata;
  logic pready;
  logic pslverr;
  logic timer_clock_gate = 1'b1;
  logic count_trigger = 1'b0;
  logic stop_trigger = 1'b0;
  logic timer_clock_run;
  logic zero_irq;
  logic irq;
  int mismatches = 0;
  int checks_done = 0;
  int cyc = 0;
  int last_z = 0;
  int exp_gap = 0;
  int pulses = 0;
  logic prev_z = 1'b0;
  logic err;
  logic [31:0] rd;
  logic [31:0] rd2;
  logic [31:0] rl;
  logic [11:0] offs [8] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010,
                            12'h020, 12'h030, 12'h034};
  logic [4:0] modes [3] = '{5'h11, 5'h19, 5'h01};

  always #50 sys_clk = ~sys_clk;

  cdt_timer #(.CNT_W(32), .PERIPH_ID(ID_VAL)) DUT (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .timer_clock_gate(timer_clock_gate), .count_trigger(count_trigger),
    .stop_trigger(stop_trigger), .timer_clock_run(timer_clock_run),
    .zero_irq(zero_irq), .irq(irq)
  );

  // ==========================================================
  // Reporting
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Pulses in a three-period window, zero when the interrupt is off
  function automatic logic [31:0] exp_pulses(input logic [4:0] mode);
    return mode[CDT_BIT_ZIRQ] ? 32'h3 : 32'h0;
  endfunction

  task automatic final_report();
    if (mismatches == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // APB master, request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  task automatic rdr(input logic [11:0] a, output logic [31:0] q);
    apb(1'b0, a, 32'h0, q);
  endtask

  task automatic start(input logic [31:0] r, input logic [31:0] c);
    wr(CDT_OFS_RELOAD, r);
    wr(CDT_OFS_COUNT, r);
    wr(CDT_OFS_CTRL, c);
  endtask

  // ==========================================================
  // Expiry pulse monitor and cycle ceiling
  always @(negedge sys_clk) begin
    cyc++;
    if (zero_irq === 1'b1) begin
      pulses++;
      check("zero_irq width", {31'h0, prev_z}, 32'h0);
      if (exp_gap > 0) check("expiry spacing", cyc - last_z, exp_gap);
      last_z = cyc;
    end
    prev_z = zero_irq;
    if (cyc > 20000) begin
      mismatches++;
      final_report();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    rl = $urandom(32'ha861);
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    check("pready", {31'h0, pready}, 32'h1);
    foreach (offs[i]) begin
      rdr(offs[i], rd);
      check("reset value", rd, 32'h0);
    end
    rdr(CDT_OFS_PERID, rd);
    check("peripheral id", rd, ID_VAL);
    rdr(12'h040, rd);
    check("unmapped read data", rd, 32'h0);
    check("unmapped read err", {31'h0, err}, 32'h1);
    wr(12'h044, 32'hffff_ffff);
    check("unmapped write err", {31'h0, err}, 32'h1);
    rd2 = $urandom;
    wr(CDT_OFS_CMPA, rd2);
    rdr(CDT_OFS_CMPA, rd);
    check("compare a level", rd, rd2);
    wr(CDT_OFS_COUNT, rd2 ^ 32'h5a5a_0000);
    rdr(CDT_OFS_COUNT, rd);
    check("count readback", rd, rd2 ^ 32'h5a5a_0000);
    // Continuous, idle-at-zero and no-interrupt modes
    foreach (modes[m]) begin
      rl = 4 + ($urandom % 8);
      pulses = 0;
      wr(CDT_OFS_RELOAD, rl);
      wr(CDT_OFS_COUNT, rl);
      wr(CDT_OFS_CTRL, {27'h0, modes[m]});
      last_z = cyc;
      exp_gap = rl + 1;
      repeat (3 * (rl + 1) + 1) @(posedge sys_clk);
      check("expiry pulses", pulses, exp_pulses(modes[m]));
      rdr(CDT_OFS_CTRL, rd);
      check("mode ctrl", rd & 32'h1d, {27'h0, modes[m]});
      if (m == 0) check("active running", rd & 32'h2, 32'h2);
      exp_gap = 0;
      wr(CDT_OFS_CTRL, {27'h0, modes[m] & 5'h1e});
      rdr(CDT_OFS_CTRL, rd);
      check("disable clears active", rd & 32'h3, 32'h0);
      rdr(CDT_OFS_COUNT, rd);
      rdr(CDT_OFS_COUNT, rd2);
      check("count frozen", rd2, rd);
    end
    // Interrupt status, mask and clear
    rdr(CDT_OFS_IRQ_STAT, rd);
    check("expiry status", rd & 32'h3, 32'h1);
    @(negedge sys_clk);
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(CDT_OFS_IRQ_EN, 32'h3);
    @(negedge sys_clk);
    check("irq enabled", {31'h0, irq}, 32'h1);
    wr(CDT_OFS_IRQ_CLR, 32'h3);
    @(negedge sys_clk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    rdr(CDT_OFS_IRQ_CLR, rd);
    check("clear reads zero", rd, 32'h0);
    // Stop at zero
    start(rl, 32'h5);
    repeat (rl + 4) @(posedge sys_clk);
    rdr(CDT_OFS_CTRL, rd);
    check("stop at zero ctrl", rd & 32'h1f, 32'h4);
    rdr(CDT_OFS_COUNT, rd);
    check("stop at zero count", rd, 32'h0);
    // Clock gate
    timer_clock_gate <= 1'b0;
    start(rl, 32'h1);
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    check("gate closed run", {31'h0, timer_clock_run}, 32'h0);
    rdr(CDT_OFS_COUNT, rd);
    check("gate closed count", rd, rl);
    timer_clock_gate <= 1'b1;
    repeat (3) @(posedge sys_clk);
    timer_clock_gate <= 1'b0;
    @(negedge sys_clk);
    check("deferred gating", {31'h0, timer_clock_run}, 32'h1);
    rdr(CDT_OFS_COUNT, rd);
    rdr(CDT_OFS_COUNT, rd2);
    check("counts while active", {31'h0, rd !== rd2}, 32'h1);
    wr(CDT_OFS_CTRL, 32'h0);
    @(negedge sys_clk);
    check("gate released", {31'h0, timer_clock_run}, 32'h0);
    @(posedge sys_clk);
    timer_clock_gate <= 1'b1;
    // zero interrupt on for cascade use
    wr(CDT_OFS_CTRL, 32'h10);
    // Cascade count condition and stop trigger
    wr(CDT_OFS_CASCADE, 32'h1);
    wr(CDT_OFS_COUNT, rl);
    wr(CDT_OFS_ENABLE, 32'h1);
    repeat (4) @(posedge sys_clk);
    rdr(CDT_OFS_COUNT, rd);
    check("cascade wait", rd, rl);
    rdr(CDT_OFS_CTRL, rd);
    check("enable via enable reg", rd & 32'h3, 32'h1);
    count_trigger <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rdr(CDT_OFS_COUNT, rd);
    check("cascade counts", {31'h0, rd !== rl}, 32'h1);
    wr(CDT_OFS_CASCADE, 32'h3);
    stop_trigger <= 1'b1;
    @(posedge sys_clk);
    stop_trigger <= 1'b0;
    rdr(CDT_OFS_CTRL, rd);
    check("stop trigger ctrl", rd & 32'h3, 32'h0);
    rdr(CDT_OFS_IRQ_STAT, rd);
    check("stop event status", rd & 32'h2, 32'h2);
    final_report();
  end
endmodule
